// ### rtl/bitstream_port_pkg.sv
// constants, field layouts and state types of the serial bitstream port
package bitstream_port_pkg;

	// ==================== register bus ====================
	localparam int            ADDR_W      = 4;
	localparam int            DATA_W      = 16;
	localparam logic [3:0]    CFG0_ADDR   = 4'h0;
	localparam logic [3:0]    STATUS_ADDR = 4'h1;
	localparam logic [15:0]   CFG0_RESET  = 16'h0000;

	// ==================== configuration fields ====================
	localparam int REQ_POL_BIT    = 7;
	localparam int REQ_USE_BIT    = 6;
	localparam int LAUNCH_BIT     = 5;
	localparam int CAPTURE_BIT    = 4;
	localparam int CLK_DIR_BIT    = 3;
	localparam int QUAL_POL_BIT   = 2;
	localparam int DATA_DIR_BIT   = 1;
	localparam int ENABLE_BIT     = 0;
	localparam int CFG_W          = 8;

	// ==================== status fields ====================
	localparam int ST_TX_PTR_LSB  = 0;
	localparam int ST_RX_PTR_LSB  = 3;
	localparam int ST_TX_BUSY_BIT = 6;
	localparam int ST_HOLD_BIT    = 7;
	localparam int ST_RUN_BIT     = 8;

	// ==================== link framing and timing ====================
	localparam int           BYTE_W      = 8;
	localparam int           PTR_W       = 3;
	localparam logic [2:0]   LAST_BIT    = 3'h7;
	localparam int           DIV_W       = 8;
	localparam int           SYS_CLK_NS  = 100;
	localparam int           LINK_HALF_NS = 400;
	localparam int           LINK_HALF_CYC = (LINK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

	// field order matches bits 7..0 of the configuration register
	typedef struct packed {
		logic request_polarity;
		logic request_line_use;
		logic launch_edge_sel;
		logic capture_edge_sel;
		logic clock_direction;
		logic qualifier_polarity;
		logic data_direction;
		logic port_enable;
	} cfg_s;

	typedef struct packed {
		logic clk;
		logic data;
		logic qual;
		logic req;
	} pins_s;

	typedef struct packed {
		cfg_s              cfg;
		logic              run;
		pins_s             sync1;
		pins_s             sync2;
		logic              clk_prev;
		logic [DIV_W-1:0]  div_cnt;
		logic              gen_clk;
		logic [PTR_W-1:0]  rx_ptr;
		logic [BYTE_W-1:0] rx_shift;
		logic [BYTE_W-1:0] rx_byte;
		logic              rx_valid;
		logic [BYTE_W-1:0] tx_hold;
		logic              tx_room;
		logic [BYTE_W-1:0] tx_shift;
		logic [PTR_W-1:0]  tx_ptr;
		logic              tx_busy;
		pins_s             pin_out;
		pins_s             pin_oe;
		logic [DATA_W-1:0] rdata;
	} state_s;

	localparam state_s STATE_RESET = '{
		cfg: cfg_s'(CFG0_RESET[CFG_W-1:0]),
		tx_room: 1'b1,
		default: '0
	};

endpackage : bitstream_port_pkg

// ### rtl/bitstream_port_config.sv
// serial bitstream port: configuration register, link clock edges, serializer and de-serializer
`timescale 1ns/1ns
`default_nettype none

module bitstream_port_config #(
	parameter int LINK_HALF = bitstream_port_pkg::LINK_HALF_CYC
) (
	// clock and reset
	input  wire logic                                 sys_clk_in,
	input  wire logic                                 rst_in,
	// register port
	input  wire logic [bitstream_port_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [bitstream_port_pkg::DATA_W-1:0] reg_wdata_in,
	input  wire logic                                 reg_write_in,
	input  wire logic                                 reg_read_in,
	output logic      [bitstream_port_pkg::DATA_W-1:0] reg_rdata_out,
	// user byte side
	input  wire logic [bitstream_port_pkg::BYTE_W-1:0] tx_byte_in,
	input  wire logic                                 tx_valid_in,
	output logic                                      tx_ready_out,
	output logic      [bitstream_port_pkg::BYTE_W-1:0] rx_byte_out,
	output logic                                      rx_valid_out,
	input  wire logic                                 rx_ready_in,
	// link pins
	input  wire bitstream_port_pkg::pins_s            stream_pins_in,
	output var  bitstream_port_pkg::pins_s            stream_pins_out,
	output var  bitstream_port_pkg::pins_s            stream_pins_oe_out
);

	// ==================== elaboration checks ====================
	if (LINK_HALF < 1 || LINK_HALF >= (1 << bitstream_port_pkg::DIV_W))
	begin : g_bad_half
		$error("LINK_HALF out of range of the clock divider");
	end

	localparam logic [bitstream_port_pkg::DIV_W-1:0] HALF_LAST =
		bitstream_port_pkg::DIV_W'(LINK_HALF - 1);

	// ==================== state ====================
	bitstream_port_pkg::state_s state_reg;
	bitstream_port_pkg::state_s state_next;

	function automatic logic pick_edge(input logic falling, input logic rise, input logic fall);
		pick_edge = falling ? fall : rise;
	endfunction : pick_edge

	always_comb
	begin
		logic                                   link_clk;
		logic                                   rise;
		logic                                   fall;
		logic                                   launch;
		logic                                   capture;
		logic                                   qual_active;
		logic                                   req_active;
		logic                                   req_ok;
		logic                                   start;
		logic [bitstream_port_pkg::BYTE_W-1:0]  word;
		bitstream_port_pkg::cfg_s               c;
		link_clk    = 1'b0;
		rise        = 1'b0;
		fall        = 1'b0;
		launch      = 1'b0;
		capture     = 1'b0;
		qual_active = 1'b0;
		req_active  = 1'b0;
		req_ok      = 1'b0;
		start       = 1'b0;
		word        = '0;
		c           = state_reg.cfg;
		state_next  = state_reg;

		// two-stage synchronisers; only stage two is looked at
		state_next.sync1 = stream_pins_in;
		state_next.sync2 = state_reg.sync1;

		// ==================== link clock ====================
		// clock source select
		link_clk = c.clock_direction ? state_reg.gen_clk : state_reg.sync2.clk;
		state_next.clk_prev = link_clk;
		rise = link_clk & ~state_reg.clk_prev;
		fall = ~link_clk & state_reg.clk_prev;
		launch  = pick_edge(c.launch_edge_sel, rise, fall);
		capture = pick_edge(c.capture_edge_sel, rise, fall);

		if (c.clock_direction && state_reg.run)
		begin
			if (state_reg.div_cnt == HALF_LAST)
			begin
				state_next.div_cnt = '0;
				state_next.gen_clk = ~state_reg.gen_clk;
			end
			else
			begin
				state_next.div_cnt = state_reg.div_cnt + 1'b1;
			end
		end
		else
		begin
			state_next.div_cnt = '0;
			state_next.gen_clk = 1'b0;
		end

		qual_active = state_reg.sync2.qual ^ c.qualifier_polarity;
		req_active  = state_reg.sync2.req ^ c.request_polarity;
		req_ok      = ~c.request_line_use | req_active;

		// ==================== register writes ====================
		if (reg_write_in && reg_addr_in == bitstream_port_pkg::CFG0_ADDR)
		begin
			state_next.cfg = bitstream_port_pkg::cfg_s'(reg_wdata_in[bitstream_port_pkg::CFG_W-1:0]);
		end
		// enable acts a cycle after its write so the other settings settle first
		state_next.run = state_reg.cfg.port_enable;

		// ==================== user byte side ====================
		state_next.rx_valid = 1'b0;
		if (tx_valid_in && state_reg.tx_room)
		begin
			state_next.tx_hold = tx_byte_in;
			state_next.tx_room = 1'b0;
		end

		// idle levels on the link
		state_next.pin_out.clk  = state_reg.gen_clk;
		state_next.pin_out.qual = c.qualifier_polarity;
		state_next.pin_out.data = 1'b0;

		if (!state_reg.run)
		begin
			// disabled: pointers and shift register cleared, no link bits move or latch
			state_next.rx_ptr   = '0;
			state_next.rx_shift = '0;
			state_next.tx_ptr   = '0;
			state_next.tx_busy  = 1'b0;
			state_next.pin_out.qual = c.qualifier_polarity;
		end
		else if (!c.data_direction)
		begin
			// capture only while the qualifier is asserted
			if (capture && qual_active)
			begin
				state_next.rx_shift = {state_reg.rx_shift[bitstream_port_pkg::BYTE_W-2:0],
					state_reg.sync2.data};
				state_next.rx_ptr = state_reg.rx_ptr + 1'b1;
				// byte boundary counted from the enabling point
				if (state_reg.rx_ptr == bitstream_port_pkg::LAST_BIT)
				begin
					state_next.rx_byte  = {state_reg.rx_shift[bitstream_port_pkg::BYTE_W-2:0],
						state_reg.sync2.data};
					state_next.rx_valid = 1'b1;
				end
			end
		end
		else
		begin
			word  = state_reg.tx_busy ? state_reg.tx_shift : state_reg.tx_hold;
			// a started byte runs to its end whatever the request does
			start = launch && (state_reg.tx_busy || (!state_reg.tx_room && req_ok));
			if (start)
			begin
				state_next.pin_out.data = word[bitstream_port_pkg::BYTE_W-1];
				state_next.pin_out.qual = ~c.qualifier_polarity;
				state_next.tx_shift     = {word[bitstream_port_pkg::BYTE_W-2:0], 1'b0};
				state_next.tx_ptr       = state_reg.tx_ptr + 1'b1;
				state_next.tx_busy      = state_reg.tx_ptr != bitstream_port_pkg::LAST_BIT;
				if (!state_reg.tx_busy)
				begin
					state_next.tx_room = 1'b1;
				end
			end
			else if (launch)
			begin
				state_next.pin_out.qual = c.qualifier_polarity;
			end
			else
			begin
				state_next.pin_out.qual = state_reg.pin_out.qual;
				state_next.pin_out.data = state_reg.pin_out.data;
			end
		end

		// request follows user readiness only while running; its pin is driven only while receiving
		state_next.pin_out.req = (rx_ready_in & state_reg.run) ^ c.request_polarity;

		state_next.pin_oe.clk  = c.clock_direction;
		state_next.pin_oe.data = c.data_direction;
		state_next.pin_oe.qual = c.data_direction;
		state_next.pin_oe.req  = ~c.data_direction & c.request_line_use;

		// ==================== register reads ====================
		state_next.rdata = '0;
		if (reg_read_in)
		begin
			unique case (reg_addr_in)
				bitstream_port_pkg::CFG0_ADDR:
				begin
					state_next.rdata[bitstream_port_pkg::CFG_W-1:0] = state_reg.cfg;
				end
				bitstream_port_pkg::STATUS_ADDR:
				begin
					state_next.rdata[bitstream_port_pkg::ST_TX_PTR_LSB +: bitstream_port_pkg::PTR_W] =
						state_reg.tx_ptr;
					state_next.rdata[bitstream_port_pkg::ST_RX_PTR_LSB +: bitstream_port_pkg::PTR_W] =
						state_reg.rx_ptr;
					state_next.rdata[bitstream_port_pkg::ST_TX_BUSY_BIT] = state_reg.tx_busy;
					state_next.rdata[bitstream_port_pkg::ST_HOLD_BIT]    = ~state_reg.tx_room;
					state_next.rdata[bitstream_port_pkg::ST_RUN_BIT]     = state_reg.run;
				end
				default:
				begin
					state_next.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			state_reg <= bitstream_port_pkg::STATE_RESET;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ==================== outputs ====================
	assign reg_rdata_out      = state_reg.rdata;
	assign tx_ready_out       = state_reg.tx_room;
	assign rx_byte_out        = state_reg.rx_byte;
	assign rx_valid_out       = state_reg.rx_valid;
	assign stream_pins_out    = state_reg.pin_out;
	assign stream_pins_oe_out = state_reg.pin_oe;

endmodule : bitstream_port_config

`default_nettype wire

// ### sim/bitstream_port_checker.sv
// concurrent checks on the bitstream port's register and pin behaviour
`timescale 1ns/1ns
`default_nettype none
module bitstream_port_checker #(
	parameter int LINK_HALF = 4
) (
	// clock and reset
	input wire logic				sys_clk_in,
	input wire logic				rst_in,
	// register port
	input wire logic [3:0]			reg_addr_in,
	input wire logic [15:0]			reg_wdata_in,
	input wire logic				reg_write_in,
	input wire logic				reg_read_in,
	input wire logic [15:0]			reg_rdata_out,
	// user byte side
	input wire logic [7:0]			tx_byte_in,
	input wire logic				tx_valid_in,
	input wire logic				tx_ready_out,
	input wire logic [7:0]			rx_byte_out,
	input wire logic				rx_valid_out,
	input wire logic				rx_ready_in,
	// link pins
	input wire bitstream_port_pkg::pins_s	stream_pins_in,
	input wire bitstream_port_pkg::pins_s	stream_pins_out,
	input wire bitstream_port_pkg::pins_s	stream_pins_oe_out
);
	// =====
	// shadow settings; counters say how long settings and the off state have held
	bitstream_port_pkg::cfg_s	cfg_q;
	logic [3:0]					off_cnt;
	logic [3:0]					still_cnt;
	always_ff @(posedge sys_clk_in)
	begin
		cfg_q <= rst_in ? '0 : (reg_write_in && reg_addr_in == 4'h0)
			? bitstream_port_pkg::cfg_s'(reg_wdata_in[7:0]) : cfg_q;
		off_cnt <= (rst_in || cfg_q.port_enable) ? 4'h0 : off_cnt + 4'(off_cnt != 4'hf);
		still_cnt <= (rst_in || reg_write_in) ? 4'h0 : still_cnt + 4'(still_cnt != 4'hf);
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// =====
	// assertions
	a_cfg_readback: assert property ($past(reg_read_in && reg_addr_in == 4'h0) |-> reg_rdata_out == {8'h00, $past(cfg_q)})
		else $error("config read back wrong");
	a_unmapped_zero: assert property ($past(reg_read_in && reg_addr_in > 4'h1) |-> reg_rdata_out == 16'h0000)
		else $error("unmapped read not zero");
	a_off_ptr_home: assert property ($past(reg_read_in && reg_addr_in == 4'h1 && off_cnt > 4'h2)
		|-> reg_rdata_out[5:3] == 3'h0 && !reg_rdata_out[8])
		else $error("pointer or run set while off");
	a_off_no_byte: assert property (off_cnt > 4'h2 |-> !rx_valid_out)
		else $error("byte delivered while off");
	a_tx_take_byte: assert property (tx_valid_in && tx_ready_out |=> !tx_ready_out)
		else $error("holding byte not taken");
	a_req_level: assert property (still_cnt > 4'h2 && !cfg_q.data_direction && cfg_q.request_line_use
		|-> stream_pins_out.req == (($past(rx_ready_in) & cfg_q.port_enable) ^ cfg_q.request_polarity))
		else $error("request level wrong");
	a_clk_dir_oe: assert property (still_cnt > 4'h1 |-> stream_pins_oe_out.clk == cfg_q.clock_direction)
		else $error("clock enable not following direction");
	a_dir_split: assert property (still_cnt > 4'h1 |-> (cfg_q.data_direction ? !stream_pins_oe_out.req
		: !(stream_pins_oe_out.data || stream_pins_oe_out.qual)))
		else $error("pin driven against data direction");
endmodule : bitstream_port_checker
bind bitstream_port_config bitstream_port_checker #(.LINK_HALF(LINK_HALF)) i_checker (.*);
`default_nettype wire

// ### sim/stream_sender.sv
// far-end transmitter model: link clock, serial data and qualifier
`timescale 1ns/1ns
`default_nettype none
module stream_sender (
	// link pins toward the port
	output var logic	clk_out = 1'b0,
	output var logic	data_out = 1'b0,
	output var logic	qual_out = 1'b0
);
	// =====
	// msb first, qualifier at its level, clock only inside frames
	task automatic send(input logic [7:0] b, input int n, input logic act, input logic pol);
		// odd offset keeps link edges off the system clock edges
		#37;
		for (int i = 7; i > 7 - n; i--)
		begin
			data_out = b[i];
			qual_out = act ^ pol;
			#200 clk_out = 1'b1;
			#400 clk_out = 1'b0;
			#200;
		end
		// released data shows the inverse, never a stale copy
		qual_out = pol;
		data_out = ~data_out;
	endtask : send
endmodule : stream_sender
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench: registers, receive and transmit paths of the bitstream port
`timescale 1ns/1ns
`default_nettype none
module testbench;
	// =====
	// design signals and bench state
	logic				sys_clk_in = 1'b0;
	logic				rst_in = 1'b1;
	logic [3:0]			reg_addr_in = 4'h0;
	logic [15:0]		reg_wdata_in = 16'h0000;
	logic				reg_write_in = 1'b0;
	logic				reg_read_in = 1'b0;
	logic [15:0]		reg_rdata_out;
	logic [7:0]			tx_byte_in = 8'h00;
	logic				tx_valid_in = 1'b0;
	logic				tx_ready_out;
	logic [7:0]			rx_byte_out;
	logic				rx_valid_out;
	logic				rx_ready_in = 1'b0;
	bitstream_port_pkg::pins_s	stream_pins_in;
	bitstream_port_pkg::pins_s	stream_pins_out;
	bitstream_port_pkg::pins_s	stream_pins_oe_out;
	logic				far_clk;
	logic				far_data;
	logic				far_qual;
	logic				far_req = 1'b0;
	logic				far_prev = 1'b0;
	logic				far_rise = 1'b0;
	logic				far_qpol = 1'b0;
	logic [7:0]			far_shift = 8'h00;
	logic [7:0]			b;
	logic [7:0]			c;
	logic [7:0]			exp_q[$];
	int					far_bits = 0;
	int					failures = 0;
	int					compares = 0;
	int					seed = 6;
	initial
	begin
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	bitstream_port_config i_dut (.*);
	stream_sender i_far (.clk_out(far_clk), .data_out(far_data), .qual_out(far_qual));
	// each wire carries whoever enables it; the far end holds the rest
	assign stream_pins_in = bitstream_port_pkg::pins_s'((stream_pins_out & stream_pins_oe_out)
		| ({far_clk, far_data, far_qual, far_req} & ~stream_pins_oe_out));
	// =====
	// shared tasks
	task automatic check(input logic [15:0] got, input logic [15:0] e);
		compares++;
		if (got !== e)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
		end
	endtask : check
	task automatic write(input logic [3:0] a, input logic [15:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_write_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask : write
	task automatic read_check(input logic [3:0] a, input logic [15:0] e);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_read_in <= 1'b0;
		// read data stand until this edge; take them before they clear
		@(posedge sys_clk_in);
		check(reg_rdata_out, e);
	endtask : read_check
	task automatic wait_bits(input int n);
		for (int i = 0; i < 500 && far_bits < n; i++)
			@(posedge sys_clk_in);
		failures += int'(far_bits < n);
		if (far_bits < n)
			print_verdict();
	endtask : wait_bits
	task automatic print_verdict();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	// =====
	// byte model on the user side, bit capture on the far side (edge opposite to launch)
	always @(posedge sys_clk_in)
		if (rx_valid_out === 1'b1)
			check({8'h00, rx_byte_out}, exp_q.size() > 0 ? {8'h00, exp_q.pop_front()} : 16'h01ff);
	always @(posedge sys_clk_in)
	begin
		far_prev <= stream_pins_out.clk;
		if ((far_rise ? (!far_prev && stream_pins_out.clk) : (far_prev && !stream_pins_out.clk))
			&& (stream_pins_out.qual ^ far_qpol) && stream_pins_oe_out.data)
		begin
			far_shift <= {far_shift[6:0], stream_pins_out.data};
			far_bits <= far_bits + 1;
		end
	end
	// =====
	// main sequence
	initial
	begin
		repeat (6) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		@(posedge sys_clk_in);
		read_check(4'h0, 16'h0000);
		read_check(4'h9, 16'h0000);
		for (int k = 0; k < 4; k++)
		begin
			b = 8'($random(seed));
			c = {b[0], 1'b1, 1'b0, k[0], 1'b0, k[1], 2'b00};
			rx_ready_in <= b[1];
			write(4'h0, {8'h00, c});
			read_check(4'h0, {8'h00, c});
			i_far.send(b, 8, 1'b1, k[1]);
			write(4'h0, {8'h00, c | 8'h01});
			i_far.send(b, 3, 1'b1, k[1]);
			write(4'h0, {8'h00, c ^ 8'h10});
			repeat (3) @(posedge sys_clk_in);
			read_check(4'h1, 16'h0000);
			write(4'h0, {8'h00, c | 8'h01});
			i_far.send(~b, 8, 1'b0, k[1]);
			exp_q.push_back(b);
			i_far.send(b, 8, 1'b1, k[1]);
			for (int i = 0; i < 50 && exp_q.size() > 0; i++)
				@(posedge sys_clk_in);
			check(16'(exp_q.size()), 16'h0000);
		end
		// transmit with generated clock; request drops mid-byte, the byte still completes
		far_req <= 1'b1;
		write(4'h0, 16'h004a);
		write(4'h0, 16'h004b);
		tx_byte_in <= b;
		tx_valid_in <= 1'b1;
		@(posedge sys_clk_in);
		tx_valid_in <= 1'b0;
		wait_bits(3);
		far_req <= 1'b0;
		wait_bits(8);
		check({8'h00, far_shift}, {8'h00, b});
		// second byte: falling launch, active-low qualifier and request, sampled on rising link clock
		write(4'h0, 16'h0000);
		b = 8'($random(seed));
		far_rise <= 1'b1;
		far_qpol <= 1'b1;
		far_req <= 1'b0;
		write(4'h0, 16'h00ee);
		write(4'h0, 16'h00ef);
		tx_byte_in <= b;
		tx_valid_in <= 1'b1;
		@(posedge sys_clk_in);
		tx_valid_in <= 1'b0;
		wait_bits(11);
		far_req <= 1'b1;
		wait_bits(16);
		check({8'h00, far_shift}, {8'h00, b});
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
